// ---- rtl/cmpev_top.sv ----
// Comparator A event logic with control/status register and debouncer
// Functional notes
// - With the default sample clock and no debouncing the comparator output is sampled every system clock.
// - In debouncing modes with sample clock select 00 the resample delay is timed by timer one.
// - After a relevant transition the debouncer waits for two timer one overflows before resampling.
// - If the resample matches the expected level the event flag is set, otherwise the event is dropped.
// - With a free-running timer the debounced flag rises one to two time-outs after the first edge.
// - With a timer-clocked sample clock a change counts as an edge only after four agreeing samples.
// - The input connect bit routes the selected analog pin to the comparator or isolates it.
// - The event flag is set only while enabled and the sampled output meets the selected mode.
// - Hardware never clears the event flag; software writes zero to acknowledge it.
// - The event flag raises an interrupt request only while global enable bit 6 is set.
// - Clearing the enable bit forces the comparator output low and blocks new events.
// - While enabled, the digital input buffers of the four analog pins are off if those pins are input-only.
// - Reset clears the control/status register at address 97h to zero; it is not bit addressable.
// - Mode codes: low level, rise, debounced toggle, debounced rise, fall, toggle, debounced fall, high level.
`include "cmpev_regs.svh"
module cmpev_top #(
  parameter logic [1:0] OVF_WAIT = `CMPEV_OVF_WAIT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Global interrupt enable register contents
  input wire logic [7:0] global_interrupt_enable_reg,
  // Analog comparator and timers
  input wire logic comp_raw,
  input wire logic [1:0] sample_clock_select,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Analog pin control
  input wire cmpev_pkg::cmpev_pins_t pin_input_only,
  output cmpev_pkg::cmpev_pins_t pin_connect,
  output cmpev_pkg::cmpev_pins_t pin_dig_in_off,
  // Outputs
  output logic comp_out,
  output logic irq_req
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] ovf_s1_r, ovf_s2_r, ovf_d_r;
  logic comp_s1_r, comp_s2_r;

  // ****************************************
  // Control/status register
  // ****************************************
  cmpev_pkg::cmpev_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  cmpev_pkg::cmpev_pins_t conn_r, conn_nxt, doff_r, doff_nxt;
  logic cout_r, cout_nxt;

  // ****************************************
  // Event detection state
  // ****************************************
  typedef enum {CMPEV_IDLE, CMPEV_WAIT} cmpev_db_state_t;
  cmpev_db_state_t db_r, db_nxt;
  logic [1:0] ovf_cnt_r, ovf_cnt_nxt;
  logic expect_r, expect_nxt;
  logic prev_r, prev_nxt;
  logic set_evt;

  logic [2:0] ovf_rise;
  logic sample_tick;
  logic t1_tick;
  logic lvl, lvl_stb;
  logic comp_gated;

  function automatic logic is_debounced(input cmpev_pkg::cmpev_mode_t m);
    is_debounced = (m == cmpev_pkg::CMPEV_DB_TOGGLE) || (m == cmpev_pkg::CMPEV_DB_RISE)
                   || (m == cmpev_pkg::CMPEV_DB_FALL);
  endfunction : is_debounced

  // Debounced modes trigger on the transition that their code names; only select 00 then starts a wait
  function automatic logic db_trigger(input cmpev_pkg::cmpev_mode_t m, input logic rise, input logic fall);
    case (m)
      cmpev_pkg::CMPEV_DB_RISE: db_trigger = rise;
      cmpev_pkg::CMPEV_DB_FALL: db_trigger = fall;
      cmpev_pkg::CMPEV_DB_TOGGLE: db_trigger = rise | fall;
      default: db_trigger = 1'b0;
    endcase
  endfunction : db_trigger

  // Level modes fire on every sample while true, edge modes once per transition
  function automatic logic plain_trigger(input cmpev_pkg::cmpev_mode_t m, input logic lv, input logic rise,
    input logic fall);
    case (m)
      cmpev_pkg::CMPEV_LOW_LEVEL: plain_trigger = ~lv;
      cmpev_pkg::CMPEV_HIGH_LEVEL: plain_trigger = lv;
      cmpev_pkg::CMPEV_RISE: plain_trigger = rise;
      cmpev_pkg::CMPEV_FALL: plain_trigger = fall;
      cmpev_pkg::CMPEV_TOGGLE: plain_trigger = rise | fall;
      default: plain_trigger = 1'b0;
    endcase
  endfunction : plain_trigger

  // Overflow pulses are edge-detected after the second stage
  assign ovf_rise = ovf_s2_r & ~ovf_d_r;
  assign t1_tick = ovf_rise[1];
  always_comb
  begin
    case (sample_clock_select)
      2'h1: sample_tick = ovf_rise[0];
      2'h2: sample_tick = ovf_rise[1];
      2'h3: sample_tick = ovf_rise[2];
      default: sample_tick = 1'b1;
    endcase
  end

  // Disabled comparator reads as low
  assign comp_gated = comp_s2_r & ctrl_r.comparator_enable_a;

  // ****************************************
  // Sampler
  // ****************************************
  cmpev_sampler #(
    .PERSIST(`CMPEV_PERSIST)
  ) u_sampler (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sample_clock_select(sample_clock_select),
    .sample_tick(sample_tick),
    .level_in(comp_gated),
    .level_out(lvl),
    .level_stb(lvl_stb)
  );

  // ****************************************
  // Event detection and debouncing
  // ****************************************
  always_comb
  begin
    logic rise;
    logic fall;
    logic en;
    cmpev_pkg::cmpev_mode_t m;
    rise = 1'b0;
    fall = 1'b0;
    en = ctrl_r.comparator_enable_a;
    m = ctrl_r.event_mode_a;
    db_nxt = db_r;
    ovf_cnt_nxt = ovf_cnt_r;
    expect_nxt = expect_r;
    prev_nxt = prev_r;
    set_evt = 1'b0;
    // Edges only count on a sampler strobe
    if (lvl_stb)
    begin
      rise = lvl & ~prev_r;
      fall = ~lvl & prev_r;
      prev_nxt = lvl;
    end
    if (!en)
    begin
      // Disabling aborts a pending debounce wait
      db_nxt = CMPEV_IDLE;
      ovf_cnt_nxt = 2'h0;
    end
    else if (!is_debounced(m))
    begin
      // Plain modes need no wait state
      db_nxt = CMPEV_IDLE;
      ovf_cnt_nxt = 2'h0;
      if (lvl_stb)
      begin
        set_evt = plain_trigger(m, lvl, rise, fall);
      end
    end
    else
    begin
      case (db_r)
        CMPEV_IDLE:
        begin
          if (db_trigger(m, rise, fall))
          begin
            // Toggle expects the new level; edges imply their own level
            expect_nxt = lvl;
            ovf_cnt_nxt = 2'h0;
            if (sample_clock_select == `CMPEV_CLK_SYS)
            begin
              db_nxt = CMPEV_WAIT;
            end
            else
            begin
              // Timer-clocked sampling already filtered the edge
              set_evt = 1'b1;
            end
          end
        end
        CMPEV_WAIT:
        begin
          // Free-running timer: two overflows guarantee at least one full period
          if (t1_tick)
          begin
            if (ovf_cnt_r + 2'h1 >= OVF_WAIT)
            begin
              db_nxt = CMPEV_IDLE;
              ovf_cnt_nxt = 2'h0;
              // Resample the live gated level, not the filtered one
              set_evt = (comp_gated == expect_r);
              prev_nxt = comp_gated;
            end
            else
            begin
              ovf_cnt_nxt = ovf_cnt_r + 2'h1;
            end
          end
        end
        default: db_nxt = CMPEV_IDLE;
      endcase
    end
  end

  // ****************************************
  // Register port and outputs
  // ****************************************
  always_comb
  begin
    cmpev_pkg::cmpev_ctrl_t w;
    w = cmpev_pkg::cmpev_ctrl_t'(sfr_wdata);
    ctrl_nxt = ctrl_r;
    // Whole-byte writes only; the register is not bit addressable
    if (sfr_wr && sfr_addr == `CMPEV_CTRL_ADDR)
    begin
      ctrl_nxt = w;
      // Software may only clear the flag; writing one keeps it unchanged
      ctrl_nxt.event_flag_a = ctrl_r.event_flag_a & w.event_flag_a;
    end
    // A hardware set wins over a same-cycle software clear
    if (set_evt && ctrl_r.comparator_enable_a)
    begin
      ctrl_nxt.event_flag_a = 1'b1;
    end
    // Read data shows the value after this cycle's update
    rdata_nxt = (sfr_addr == `CMPEV_CTRL_ADDR) ? ctrl_nxt : 8'h00;
    // Request follows the flag, gated by the global enable
    irq_nxt = ctrl_nxt.event_flag_a & global_interrupt_enable_reg[`CMPEV_IE_BIT];
    // Pins stay isolated unless connected
    conn_nxt = '0;
    if (ctrl_nxt.input_connect_a)
    begin
      conn_nxt = cmpev_pkg::cmpev_pins_t'(4'h1 << ctrl_nxt.positive_input_select_a);
    end
    doff_nxt = ctrl_nxt.comparator_enable_a ? pin_input_only : 4'h0;
    cout_nxt = comp_gated;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ovf_s1_r <= 3'h0;
      ovf_s2_r <= 3'h0;
      ovf_d_r <= 3'h0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      ctrl_r <= `CMPEV_CTRL_RESET;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      conn_r <= '0;
      doff_r <= '0;
      cout_r <= 1'b0;
      db_r <= CMPEV_IDLE;
      ovf_cnt_r <= 2'h0;
      expect_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      // Two stages before any logic reads the asynchronous lines
      ovf_s1_r <= {timer2_ovf, timer1_ovf, timer0_ovf};
      ovf_s2_r <= ovf_s1_r;
      ovf_d_r <= ovf_s2_r;
      comp_s1_r <= comp_raw;
      comp_s2_r <= comp_s1_r;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      conn_r <= conn_nxt;
      doff_r <= doff_nxt;
      cout_r <= cout_nxt;
      db_r <= db_nxt;
      ovf_cnt_r <= ovf_cnt_nxt;
      expect_r <= expect_nxt;
      prev_r <= prev_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sfr_rdata = rdata_r;
  assign irq_req = irq_r;
  assign pin_connect = conn_r;
  assign pin_dig_in_off = doff_r;
  assign comp_out = cout_r;
endmodule : cmpev_top

// ---- rtl/cmpev_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the comparator event block
`ifndef CMPEV_REGS_SVH
`define CMPEV_REGS_SVH
`define CMPEV_CTRL_ADDR 8'h97
`define CMPEV_CTRL_RESET 8'h00
`define CMPEV_SEL_HI 7
`define CMPEV_SEL_LO 6
`define CMPEV_CON_BIT 5
`define CMPEV_FLAG_BIT 4
`define CMPEV_EN_BIT 3
`define CMPEV_MODE_HI 2
`define CMPEV_MODE_LO 0
`define CMPEV_IE_BIT 6
`define CMPEV_OVF_WAIT 2'h2
`define CMPEV_PERSIST 3'h4
`define CMPEV_CLK_SYS 2'h0
`endif

// ---- rtl/cmpev_pkg.sv ----
// Types shared by the comparator event block
package cmpev_pkg;
  typedef enum logic [2:0] {
    CMPEV_LOW_LEVEL = 3'h0,
    CMPEV_RISE = 3'h1,
    CMPEV_DB_TOGGLE = 3'h2,
    CMPEV_DB_RISE = 3'h3,
    CMPEV_FALL = 3'h4,
    CMPEV_TOGGLE = 3'h5,
    CMPEV_DB_FALL = 3'h6,
    CMPEV_HIGH_LEVEL = 3'h7
  } cmpev_mode_t;

  typedef struct packed {
    logic [1:0] positive_input_select_a;
    logic input_connect_a;
    logic event_flag_a;
    logic comparator_enable_a;
    cmpev_mode_t event_mode_a;
  } cmpev_ctrl_t;

  typedef struct packed {
    logic analog_in_three;
    logic analog_in_two;
    logic analog_in_one;
    logic analog_in_zero;
  } cmpev_pins_t;
endpackage : cmpev_pkg

// ---- rtl/cmpev_sampler.sv ----
// Comparator output sampler: plain per-cycle sampling or timer-clocked persistence filter
`include "cmpev_regs.svh"
module cmpev_sampler #(
  parameter logic [2:0] PERSIST = `CMPEV_PERSIST
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Sampling control
  input wire logic [1:0] sample_clock_select,
  input wire logic sample_tick,
  input wire logic level_in,
  // Filtered level
  output logic level_out,
  output logic level_stb
);
  logic level_r, level_nxt;
  logic stb_r, stb_nxt;
  logic cand_r, cand_nxt;
  logic [2:0] cnt_r, cnt_nxt;

  assign level_out = level_r;
  assign level_stb = stb_r;

  always_comb
  begin
    level_nxt = level_r;
    cand_nxt = cand_r;
    cnt_nxt = cnt_r;
    stb_nxt = 1'b0;
    if (sample_clock_select == `CMPEV_CLK_SYS)
    begin
      // One sample on every system clock
      level_nxt = level_in;
      stb_nxt = 1'b1;
      cnt_nxt = 3'h0;
      cand_nxt = level_in;
    end
    else if (sample_tick)
    begin
      stb_nxt = 1'b1;
      if (level_in == level_r)
      begin
        cnt_nxt = 3'h0;
        cand_nxt = level_r;
      end
      else if (level_in != cand_r)
      begin
        // New candidate, this is its first sample
        cand_nxt = level_in;
        cnt_nxt = 3'h1;
      end
      else if (cnt_r + 3'h1 >= PERSIST)
      begin
        // Change held for the full run of samples
        level_nxt = level_in;
        cnt_nxt = 3'h0;
      end
      else
      begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      level_r <= 1'b0;
      stb_r <= 1'b0;
      cand_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else
    begin
      level_r <= level_nxt;
      stb_r <= stb_nxt;
      cand_r <= cand_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : cmpev_sampler

// ---- sim/cmpev_far_model.sv ----
// Model of the analog comparator output and the free-running timers
module cmpev_far_model #(
  parameter int T0_PER = 10,
  parameter int T1_PER = 40,
  parameter int T2_PER = 12
) (
  // Clock and level command
  input wire logic clk_sys,
  input wire logic level_cmd,
  // Comparator and overflow lines
  output logic comp_raw,
  output logic timer0_ovf,
  output logic timer1_ovf,
  output logic timer2_ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Free-running timers
  // ****************
  int unsigned tick = 0;
  always @(negedge clk_sys)
  begin
    tick <= tick + 1;
  end
  // One-cycle pulses keep the gap rule of the overflow synchronisers
  assign timer0_ovf = (tick % T0_PER) == 0;
  assign timer1_ovf = (tick % T1_PER) == 0;
  assign timer2_ovf = (tick % T2_PER) == 0;
  assign comp_raw = level_cmd;
endmodule : cmpev_far_model

// ---- sim/cmpev_checker.sv ----
// Assertion checker for the comparator event block
module cmpev_checker #(
  parameter logic [1:0] OVF_WAIT = 2'h2
) (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] global_interrupt_enable_reg,
  // Comparator, timers and pins
  input wire logic comp_raw,
  input wire logic [1:0] sample_clock_select,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire cmpev_pkg::cmpev_pins_t pin_input_only,
  input wire cmpev_pkg::cmpev_pins_t pin_connect,
  input wire cmpev_pkg::cmpev_pins_t pin_dig_in_off,
  input wire logic comp_out,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire hit = sfr_addr == 8'h97;
  // Register fields are only visible while the read address stays mapped
  rst_clear_a: assert property (!$past(rstn) |-> sfr_rdata == 8'h00 && !irq_req && !comp_out)
    else $error("outputs not clear after reset");
  unmapped_zero_a: assert property (!$past(hit) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  write_take_a: assert property ($past(hit && sfr_wr) |->
    {sfr_rdata[7:5], sfr_rdata[3:0]} == $past({sfr_wdata[7:5], sfr_wdata[3:0]}))
    else $error("write not taken");
  flag_hold_a: assert property ($past(hit, 2) && $past(hit) && $past(sfr_rdata[4]) && !$past(sfr_wr)
    |-> sfr_rdata[4]) else $error("flag cleared by hardware");
  irq_gate_a: assert property (irq_req |-> $past(global_interrupt_enable_reg[6]))
    else $error("request without global enable");
  irq_follow_a: assert property ($past(hit, 2) && $past(hit) && sfr_rdata[4] && $past(sfr_rdata[4])
    && $past(global_interrupt_enable_reg[6]) |-> irq_req) else $error("request missing");
  conn_sel_a: assert property ($past(hit, 2) && $past(hit) && $stable(sfr_rdata[7:5]) |->
    pin_connect == (sfr_rdata[5] ? 4'h1 << sfr_rdata[7:6] : 4'h0)) else $error("pin routing wrong");
  dig_off_a: assert property ($past(hit, 2) && $past(hit) && $stable(sfr_rdata[3]) && $stable(pin_input_only)
    |-> pin_dig_in_off == (pin_input_only & {4{sfr_rdata[3]}})) else $error("buffer disable wrong");
  off_low_a: assert property ($past(hit, 2) && $past(hit) && !sfr_rdata[3] && !$past(sfr_rdata[3])
    |-> !comp_out && !$rose(sfr_rdata[4])) else $error("disabled comparator active");
  flag_c: cover property (hit && $rose(sfr_rdata[4]));
  irq_c: cover property ($rose(irq_req));
  out_c: cover property ($rose(comp_out) && pin_connect != 4'h0);
endmodule : cmpev_checker

bind cmpev_top cmpev_checker #(.OVF_WAIT(OVF_WAIT)) cmpev_checker_inst (.clk_sys(clk_sys), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .global_interrupt_enable_reg(global_interrupt_enable_reg), .comp_raw(comp_raw),
  .sample_clock_select(sample_clock_select), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
  .timer2_ovf(timer2_ovf), .pin_input_only(pin_input_only), .pin_connect(pin_connect),
  .pin_dig_in_off(pin_dig_in_off), .comp_out(comp_out), .irq_req(irq_req));

// ---- sim/tb_top.sv ----
// Self-checking testbench of the comparator event block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rstn, sfr_wr, level, comp_raw, comp_out, irq_req, t0, t1, t2;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, gie;
  logic [1:0] sel;
  cmpev_pkg::cmpev_pins_t pin_input_only, pin_connect, pin_dig_in_off;
  int fail_count = 0;
  int total_checks = 0;
  cmpev_top cmpev_top_inst (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .global_interrupt_enable_reg(gie), .comp_raw(comp_raw),
    .sample_clock_select(sel), .timer0_ovf(t0), .timer1_ovf(t1), .timer2_ovf(t2),
    .pin_input_only(pin_input_only), .pin_connect(pin_connect), .pin_dig_in_off(pin_dig_in_off),
    .comp_out(comp_out), .irq_req(irq_req));
  cmpev_far_model cmpev_far_model_inst (.clk_sys(clk_sys), .level_cmd(level), .comp_raw(comp_raw),
    .timer0_ovf(t0), .timer1_ovf(t1), .timer2_ovf(t2));
  // ****************
  // Helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] d);
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask : wr
  function automatic logic [7:0] ext(input logic x);
    return {7'h0, x};
  endfunction : ext
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ****************
  // Scenarios
  // ****************
  task automatic t_reg;
    chk("ctrl", 8'h00, sfr_rdata);
    wr(8'h10);
    chk("ctrl", 8'h00, sfr_rdata);
    wr(8'hc0);
    wr(8'he0);
    cyc(1);
    chk("ctrl", 8'he0, sfr_rdata);
    chk("connect", 8'h08, {4'h0, pin_connect});
    wr(8'hc0);
    wr(8'h40);
    wr(8'h68);
    cyc(1);
    chk("connect", 8'h02, {4'h0, pin_connect});
    chk("dig off", 8'h0a, {4'h0, pin_dig_in_off});
    wr(8'h00);
    cyc(1);
    chk("dig off", 8'h00, {4'h0, pin_dig_in_off});
    sfr_addr = 8'h96;
    wr(8'hff);
    chk("unmapped", 8'h00, sfr_rdata);
    sfr_addr = 8'h97;
    cyc(1);
    chk("ctrl", 8'h00, sfr_rdata);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_ev;
    logic [2:0] m [5] = '{3'h1, 3'h4, 3'h5, 3'h0, 3'h7};
    logic a [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    foreach (m[i])
    begin
      level = a[i];
      wr({5'h05, m[i]});
      cyc(10);
      wr({5'h05, m[i]});
      cyc(8);
      chk("flag idle", 8'h00, ext(sfr_rdata[4]));
      level = !a[i];
      cyc(8);
      chk("flag", 8'h01, ext(sfr_rdata[4]));
      chk("comp out", ext(!a[i]), ext(comp_out));
      chk("irq", 8'h01, ext(irq_req));
      gie = 8'h00;
      cyc(2);
      chk("irq", 8'h00, ext(irq_req));
      gie = 8'h40;
      wr(8'h00);
    end
    $display("t_ev done");
  endtask : t_ev
  task automatic t_db;
    logic [2:0] m [4] = '{3'h3, 3'h3, 3'h6, 3'h2};
    logic a [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic g [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    foreach (m[i])
    begin
      level = a[i];
      wr({5'h05, m[i]});
      cyc(100);
      wr({5'h05, m[i]});
      level = !a[i];
      cyc(5);
      if (g[i])
        level = a[i];
      cyc(30);
      chk("flag early", 8'h00, ext(sfr_rdata[4]));
      cyc(60);
      chk("flag late", ext(!g[i]), ext(sfr_rdata[4]));
      wr(8'h00);
    end
    $display("t_db done");
  endtask : t_db
  task automatic t_tc;
    int p [3] = '{10, 40, 12};
    logic [7:0] cw;
    for (int s = 1; s < 4; s++)
    begin
      sel = 2'(s);
      level = 1'b0;
      // Timer one pass uses debounced rise, which flags straight after the filter
      cw = (s == 2) ? 8'h2b : 8'h29;
      wr(cw);
      cyc(6 * p[s-1]);
      wr(cw);
      level = 1'b1;
      cyc(2 * p[s-1]);
      level = 1'b0;
      cyc(6 * p[s-1]);
      chk("short pulse", 8'h00, ext(sfr_rdata[4]));
      level = 1'b1;
      cyc(6 * p[s-1]);
      chk("held edge", 8'h01, ext(sfr_rdata[4]));
      wr(8'h00);
    end
    sel = 2'h0;
    $display("t_tc done");
  endtask : t_tc
  task automatic t_off;
    level = 1'b1;
    wr(8'h27);
    cyc(10);
    chk("comp out", 8'h00, ext(comp_out));
    chk("flag off", 8'h00, ext(sfr_rdata[4]));
    $display("t_off done");
  endtask : t_off
  // ****************
  // Run control
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    rstn = 1'b0;
    sfr_addr = 8'h97;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    gie = 8'h40;
    level = 1'b1;
    sel = 2'h0;
    pin_input_only = 4'ha;
    cyc(6);
    rstn = 1'b1;
    cyc(1);
    t_reg;
    t_ev;
    t_db;
    t_tc;
    t_off;
    summarize;
  end
  // Whole run needs about 2300 cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    summarize;
  end
endmodule : tb_top
